// File: verilog/lfp_protect.sv
// lock-bit and fuse-bit protection for program memory
// How it works
// - app lock pair both one: stores and loads into application region unrestricted
// - app pair high one low zero: block stores into application region only
// - app pair both zero: block stores and boot loads; mask interrupts in app code
// - app pair high zero low one: block boot loads from application, mask interrupts
// - boot pair decodes alike; high one low zero blocks stores into boot region
// - boot pair both zero: block stores and application loads; mask interrupts
// - boot pair high zero low one: block application loads of boot region
// - a programmed fuse reads zero, an unprogrammed one reads one
// - extended byte: boot size defaults programmed, reset vector, or self-program enable
// - high byte holds reset disable, debug, serial enable, watchdog, preserve, brown-out
// - serial programming enable fuse is never changed over the serial interface
// - low byte holds divide by eight, clock out, start-up and source; 8MHz RC default
// - chip erase leaves every fuse bit unchanged
// - once the first memory lock bit is programmed fuse writes are refused
// - fuses latched on programming entry; changes apply after programming ends
// - eeprom preserve fuse acts at once, without waiting for latching
// - fuses are latched at power-up in normal mode
// - chip erase keeps eeprom when preserve is programmed, else erases it
// - lock bits return to one only through chip erase
// - first memory lock programmed: no further flash or eeprom programming
//
// Our own choices: the address map and the strobed register port.
`include "lfp_defs.svh"
module lfp_protect #(
   parameter bit HAS_BOOT = 1'b1
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic prog_mode_in,
   input wire lfp_pkg::lfp_prog_cmd_t prog_cmd_in,
   input wire lfp_pkg::lfp_access_req_t access_req_in,
   input wire logic cpu_in_boot_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [7:0] reg_rdata_out,
   output logic access_grant_out,
   output logic access_deny_out,
   output logic irq_disable_out,
   output logic [7:0] fuse_ext_out,
   output logic [7:0] fuse_high_out,
   output logic [7:0] fuse_low_out,
   output logic eeprom_preserve_out,
   output logic eeprom_erase_out,
   output logic mem_prog_allow_out,
   output logic prog_refused_out
);

   localparam logic [7:0] EXT_DEFAULT = HAS_BOOT ? `LFP_EXT_DEFAULT_BOOT : `LFP_EXT_DEFAULT_FLAT;

   initial
   begin
      if (HAS_BOOT !== 1'b0 && HAS_BOOT !== 1'b1)
      begin
         $error("HAS_BOOT must be 0 or 1");
      end
   end

   // nonvolatile copies and the latched copies that steer the logic
   logic [7:0] lock_byte;
   logic [7:0] extended_fuse_byte_bootsel;
   logic [7:0] fuse_high_byte;
   logic [7:0] fuse_low_byte;
   logic [7:0] lock_seen;
   logic [7:0] ext_seen;
   logic [7:0] high_seen;
   logic [7:0] low_seen;
   logic power_latched;
   logic prog_mode_q;
   logic vectors_in_boot;

   // programmer command decode
   wire is_erase = prog_cmd_in.valid && prog_cmd_in.op == lfp_pkg::LFP_OP_ERASE;
   wire is_fuse_wr = prog_cmd_in.valid && (prog_cmd_in.op == lfp_pkg::LFP_OP_WR_LOW
      || prog_cmd_in.op == lfp_pkg::LFP_OP_WR_HIGH || prog_cmd_in.op == lfp_pkg::LFP_OP_WR_EXT);
   wire is_lock_wr = prog_cmd_in.valid && prog_cmd_in.op == lfp_pkg::LFP_OP_WR_LOCK;
   wire fuses_locked = !lock_byte[`LFP_LB_MEM_FIRST];
   wire fuse_wr_ok = is_fuse_wr && prog_mode_in && !fuses_locked;
   wire lock_wr_ok = is_lock_wr && prog_mode_in;
   wire erase_ok = is_erase && prog_mode_in;

   // serial writes keep the serial enable fuse as it stands
   wire [7:0] high_wr_data = prog_cmd_in.serial
      ? {prog_cmd_in.data[7:6], fuse_high_byte[`LFP_HIGH_SERIAL_PROG], prog_cmd_in.data[4:0]}
      : prog_cmd_in.data;

   // software lock-set only programs bits, never the two unused top bits
   wire sw_lock_set = reg_write_in && reg_addr_in == `LFP_OFS_LOCK_SET;
   wire [7:0] sw_lock_mask = reg_wdata_in | `LFP_LOCK_SET_MASK;

   // lock bits may only fall, except a chip erase which restores all ones
   wire [7:0] next_lock_byte = erase_ok ? `LFP_LOCK_DEFAULT
      : lock_byte & (lock_wr_ok ? prog_cmd_in.data : 8'hFF)
        & (sw_lock_set ? sw_lock_mask : 8'hFF);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         lock_byte <= `LFP_LOCK_DEFAULT;
      else
         lock_byte <= next_lock_byte;
   end

   // fuse store; chip erase never touches it
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         extended_fuse_byte_bootsel <= EXT_DEFAULT;
         fuse_high_byte <= `LFP_HIGH_DEFAULT;
         fuse_low_byte <= `LFP_LOW_DEFAULT;
      end
      else if (fuse_wr_ok)
      begin
         // zero is programmed, stored and read as written
         unique case (prog_cmd_in.op)
            lfp_pkg::LFP_OP_WR_EXT: extended_fuse_byte_bootsel <= prog_cmd_in.data;
            lfp_pkg::LFP_OP_WR_HIGH: fuse_high_byte <= high_wr_data;
            lfp_pkg::LFP_OP_WR_LOW: fuse_low_byte <= prog_cmd_in.data;
            default: fuse_low_byte <= fuse_low_byte;
         endcase
      end
   end

   // fuse latch points: power-up, programming entry and programming exit
   wire prog_enter = prog_mode_in && !prog_mode_q;
   wire prog_leave = !prog_mode_in && prog_mode_q;
   wire fuse_latch = !power_latched || prog_enter || prog_leave;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         power_latched <= 1'b0;
         prog_mode_q <= 1'b0;
      end
      else
      begin
         power_latched <= 1'b1;
         prog_mode_q <= prog_mode_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ext_seen <= EXT_DEFAULT;
         high_seen <= `LFP_HIGH_DEFAULT;
         low_seen <= `LFP_LOW_DEFAULT;
      end
      else if (fuse_latch)
      begin
         ext_seen <= extended_fuse_byte_bootsel;
         high_seen <= fuse_high_byte;
         low_seen <= fuse_low_byte;
      end
   end

   // lock copy only moves while no access is offered, so a request sees one mode
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         lock_seen <= `LFP_LOCK_DEFAULT;
      else if (!access_req_in.valid)
         lock_seen <= lock_byte;
   end

   // protection decode on the latched copies
   wire app_hi = lock_seen[`LFP_LB_APP_HIGH];
   wire app_lo = lock_seen[`LFP_LB_APP_LOW];
   wire boot_hi = lock_seen[`LFP_LB_BOOT_HIGH];
   wire boot_lo = lock_seen[`LFP_LB_BOOT_LOW];
   wire selfprog_on = !ext_seen[`LFP_EXT_SELFPROG];
   // modes 2 and 3 block stores; modes 1 and 4 allow them
   wire app_store_ok = app_lo;
   wire boot_store_ok = boot_lo;
   // modes 3 and 4 block cross-region loads
   wire app_load_ok = app_hi || !access_req_in.from_boot;
   wire boot_load_ok = boot_hi || access_req_in.from_boot;
   wire boot_store_allow = access_req_in.to_boot ? boot_store_ok : app_store_ok;
   wire boot_load_allow = access_req_in.to_boot ? boot_load_ok : app_load_ok;
   // without a boot region the store rests on the self-program fuse alone
   wire store_allow = HAS_BOOT ? boot_store_allow : selfprog_on;
   wire load_allow = HAS_BOOT ? boot_load_allow : 1'b1;
   wire req_allow = access_req_in.store ? store_allow : load_allow;

   // interrupt masking while running in the other region
   wire irq_mask_app = !app_hi && vectors_in_boot && !cpu_in_boot_in;
   wire irq_mask_boot = !boot_hi && !vectors_in_boot && cpu_in_boot_in;
   wire next_irq_disable = HAS_BOOT && (irq_mask_app || irq_mask_boot);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         access_grant_out <= 1'b0;
         access_deny_out <= 1'b0;
         irq_disable_out <= 1'b0;
      end
      else
      begin
         access_grant_out <= access_req_in.valid && req_allow;
         access_deny_out <= access_req_in.valid && !req_allow;
         irq_disable_out <= next_irq_disable;
      end
   end

   // preserve fuse read live from the store, not the latch
   wire preserve_live = !fuse_high_byte[`LFP_HIGH_EEPROM_PRESERVE];
   wire refused = (is_fuse_wr || is_lock_wr || is_erase) && !(fuse_wr_ok || lock_wr_ok
      || erase_ok);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         eeprom_erase_out <= 1'b0;
         eeprom_preserve_out <= 1'b0;
         mem_prog_allow_out <= 1'b1;
         prog_refused_out <= 1'b0;
         fuse_ext_out <= EXT_DEFAULT;
         fuse_high_out <= `LFP_HIGH_DEFAULT;
         fuse_low_out <= `LFP_LOW_DEFAULT;
      end
      else
      begin
         eeprom_erase_out <= erase_ok && !preserve_live;
         eeprom_preserve_out <= preserve_live;
         mem_prog_allow_out <= !fuses_locked;
         prog_refused_out <= refused;
         fuse_ext_out <= ext_seen;
         fuse_high_out <= high_seen;
         fuse_low_out <= low_seen;
      end
   end

   // control register: where the interrupt vectors sit
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         vectors_in_boot <= 1'b0;
      else if (reg_write_in && reg_addr_in == `LFP_OFS_CTRL)
         vectors_in_boot <= reg_wdata_in[0];
   end

   // read mux; unmapped offsets read zero
   wire [7:0] status_word = {5'h00, prog_mode_q, fuses_locked, power_latched};
   logic [7:0] read_word;
   always_comb
   begin
      unique case (reg_addr_in)
         `LFP_OFS_LOCK: read_word = lock_byte;
         `LFP_OFS_EXT: read_word = extended_fuse_byte_bootsel;
         `LFP_OFS_HIGH: read_word = fuse_high_byte;
         `LFP_OFS_LOW: read_word = fuse_low_byte;
         `LFP_OFS_CTRL: read_word = {7'h00, vectors_in_boot};
         `LFP_OFS_STATUS: read_word = status_word;
         default: read_word = 8'h00;
      endcase
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         reg_rdata_out <= 8'h00;
      else
         reg_rdata_out <= reg_read_in ? read_word : 8'h00;
   end

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_erase;
      prog_cmd_in.valid && prog_cmd_in.op == lfp_pkg::LFP_OP_ERASE && prog_mode_in;
   endsequence

   sequence s_locked_fuse_write;
      is_fuse_wr && !lock_byte[`LFP_LB_MEM_FIRST];
   endsequence

   fuse_lock_hold_a: assert property (s_locked_fuse_write |=>
      $stable(fuse_high_byte) && $stable(fuse_low_byte) && prog_refused_out)
      else $error("fuse changed while locked");

   erase_keeps_fuse_a: assert property (s_erase |=>
      $stable(fuse_high_byte) && $stable(fuse_low_byte) && lock_byte == 8'hFF)
      else $error("chip erase disturbed fuses or locks");

   serial_fuse_keep_a: assert property (prog_cmd_in.valid && prog_cmd_in.serial
      |=> fuse_high_byte[5] == $past(fuse_high_byte[5]))
      else $error("serial enable fuse changed over serial");

   app_store_block_a: assert property (access_req_in.valid && access_req_in.store
      && !access_req_in.to_boot && !lock_seen[2] && HAS_BOOT
      |=> access_deny_out && !access_grant_out)
      else $error("application store not blocked");

   boot_load_block_a: assert property (access_req_in.valid && !access_req_in.store
      && access_req_in.to_boot && !access_req_in.from_boot && !lock_seen[5] && HAS_BOOT
      |=> access_deny_out)
      else $error("application load of boot region not blocked");

   app_open_a: assert property (access_req_in.valid && !access_req_in.to_boot
      && lock_seen[3:2] == 2'b11 && HAS_BOOT |=> access_grant_out)
      else $error("unlocked application access denied");

   latch_hold_a: assert property (prog_mode_in && prog_mode_q ##1 prog_mode_in
      |=> $stable(fuse_high_out) && $stable(fuse_low_out))
      else $error("latched fuses moved inside programming mode");

   eeprom_save_a: assert property (s_erase |=>
      eeprom_erase_out == $past(fuse_high_byte[3]))
      else $error("eeprom erase disagrees with preserve fuse");

   lock_rise_a: assert property (!is_erase |=>
      (lock_byte & ~$past(lock_byte)) == 8'h00)
      else $error("lock bit cleared without chip erase");

endmodule : lfp_protect

// File: verilog/lfp_defs.svh
// offsets, field positions and reset values of the lock and fuse protection block
`ifndef LFP_DEFS_SVH
`define LFP_DEFS_SVH

// register offsets on the plain register port
`define LFP_OFS_LOCK 4'h0
`define LFP_OFS_EXT 4'h1
`define LFP_OFS_HIGH 4'h2
`define LFP_OFS_LOW 4'h3
`define LFP_OFS_CTRL 4'h4
`define LFP_OFS_STATUS 4'h5
`define LFP_OFS_LOCK_SET 4'h6

// lock byte field positions
`define LFP_LB_MEM_FIRST 0
`define LFP_LB_MEM_SECOND 1
`define LFP_LB_APP_LOW 2
`define LFP_LB_APP_HIGH 3
`define LFP_LB_BOOT_LOW 4
`define LFP_LB_BOOT_HIGH 5

// fuse field positions
`define LFP_EXT_SELFPROG 0
`define LFP_EXT_RESET_VEC 0
`define LFP_HIGH_SERIAL_PROG 5
`define LFP_HIGH_EEPROM_PRESERVE 3

// reset values: a one is unprogrammed, a zero programmed
`define LFP_LOCK_DEFAULT 8'hFF
`define LFP_EXT_DEFAULT_BOOT 8'hF9
`define LFP_EXT_DEFAULT_FLAT 8'hFF
`define LFP_HIGH_DEFAULT 8'hDF
`define LFP_LOW_DEFAULT 8'h62
`define LFP_LOCK_SET_MASK 8'hC0

`endif

// File: verilog/lfp_pkg.sv
// types shared by the lock and fuse protection block
package lfp_pkg;

   // programmer operations
   typedef enum logic [2:0] {
      LFP_OP_ERASE,
      LFP_OP_WR_LOW,
      LFP_OP_WR_HIGH,
      LFP_OP_WR_EXT,
      LFP_OP_WR_LOCK
   } lfp_op_t;

   // one programmer command, valid for one cycle
   typedef struct packed {
      logic valid;
      logic serial;
      lfp_op_t op;
      logic [7:0] data;
   } lfp_prog_cmd_t;

   // one cpu program-memory access request
   typedef struct packed {
      logic valid;
      logic store;
      logic from_boot;
      logic to_boot;
   } lfp_access_req_t;

endpackage : lfp_pkg

// File: tb/lfp_prog_model.sv
// programmer model that issues one-cycle commands to the protection block
module lfp_prog_model (
   input wire logic clk_in,
   output lfp_pkg::lfp_prog_cmd_t cmd_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial cmd_out = '0;

   // one command per call; the bench sends fuses and boot locks before memory locks
   task automatic send(input lfp_pkg::lfp_op_t op, input logic [7:0] data, input logic ser);
      @(posedge clk_in);
      cmd_out <= {1'b1, ser, op, data};
      @(posedge clk_in);
      // idle fields scrambled so a stale byte never passes for a command
      cmd_out <= {1'b0, ~ser, op, ~data};
   endtask : send
endmodule : lfp_prog_model

// File: tb/testbench.sv
// self-checking bench of the lock and fuse protection block
`include "lfp_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in, rst_n_in, prog_mode_in, cpu_in_boot_in, reg_write_in, reg_read_in;
   lfp_pkg::lfp_prog_cmd_t prog_cmd_in;
   lfp_pkg::lfp_access_req_t access_req_in;
   logic [3:0] reg_addr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out, fuse_ext_out, fuse_high_out, fuse_low_out;
   logic access_grant_out, access_deny_out, irq_disable_out, eeprom_preserve_out;
   logic eeprom_erase_out, mem_prog_allow_out, prog_refused_out;
   int n_errors = 0;
   int comparisons = 0;
   int seed = 7;
   logic [3:0] lk;
   logic vb, fb;

   lfp_prog_model u_prog (.clk_in, .cmd_out(prog_cmd_in));

   lfp_protect u_dut (.clk_in, .rst_n_in, .prog_mode_in, .prog_cmd_in, .access_req_in,
      .cpu_in_boot_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
      .reg_rdata_out, .access_grant_out, .access_deny_out, .irq_disable_out, .fuse_ext_out,
      .fuse_high_out, .fuse_low_out, .eeprom_preserve_out, .eeprom_erase_out,
      .mem_prog_allow_out, .prog_refused_out);

   // 40 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick

   task automatic cmd(input lfp_pkg::lfp_op_t op, input logic [7:0] data, input logic ser);
      u_prog.send(op, data, ser);
      #1;
   endtask : cmd

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clk_in);
      reg_write_in <= 1'b0;
      #1;
   endtask : reg_wr

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clk_in);
      reg_read_in <= 1'b0;
      #1;
      check("rdata", reg_rdata_out, exp);
   endtask : reg_rd

   task automatic access(input logic st, input logic f, input logic t, input logic ok);
      @(posedge clk_in);
      access_req_in <= {1'b1, st, f, t};
      cpu_in_boot_in <= f;
      @(posedge clk_in);
      access_req_in <= {1'b0, ~st, ~f, ~t};
      #1;
      check("grant deny", {6'h0, access_grant_out, access_deny_out}, {6'h0, ok, ~ok});
   endtask : access

   // l is {boot high, boot low, app high, app low}; stores need low bit, cross loads high bit
   function automatic logic acc_ok(input logic [3:0] l, input logic st, input logic f,
      input logic t);
      logic hi, lo;
      hi = t ? l[3] : l[1];
      lo = t ? l[2] : l[0];
      return st ? lo : (hi | (f == t));
   endfunction : acc_ok

   function automatic logic irq_exp(input logic v, input logic [3:0] l, input logic b);
      return v ? (~l[1] & ~b) : (~l[3] & b);
   endfunction : irq_exp

   // hang guard
   initial
   begin
      #400000;
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      rst_n_in = 1'b0;
      prog_mode_in = 1'b0;
      cpu_in_boot_in = 1'b0;
      access_req_in = '0;
      reg_addr_in = 4'h0;
      reg_wdata_in = 8'h00;
      reg_write_in = 1'b0;
      reg_read_in = 1'b0;
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      tick(3);
      check("ext", fuse_ext_out, 8'hF9);
      check("high", fuse_high_out, 8'hDF);
      check("low", fuse_low_out, 8'h62);
      reg_rd(`LFP_OFS_HIGH, 8'hDF);
      reg_rd(`LFP_OFS_LOCK, 8'hFF);
      reg_rd(4'hF, 8'h00);
      // fuse writes wait for programming exit, preserve acts at once
      prog_mode_in <= 1'b1;
      tick(2);
      cmd(lfp_pkg::LFP_OP_WR_LOW, 8'hA5, 1'b0);
      check("low held", fuse_low_out, 8'h62);
      cmd(lfp_pkg::LFP_OP_WR_EXT, 8'hF8, 1'b0);
      check("ext held", fuse_ext_out, 8'hF9);
      cmd(lfp_pkg::LFP_OP_WR_HIGH, 8'hD7, 1'b0);
      tick(1);
      check("preserve", {7'h0, eeprom_preserve_out}, 8'h01);
      cmd(lfp_pkg::LFP_OP_WR_HIGH, 8'hF7, 1'b1);
      cmd(lfp_pkg::LFP_OP_ERASE, 8'h00, 1'b0);
      check("erase kept", {7'h0, eeprom_erase_out}, 8'h00);
      prog_mode_in <= 1'b0;
      tick(3);
      check("low", fuse_low_out, 8'hA5);
      check("high", fuse_high_out, 8'hD7);
      check("ext", fuse_ext_out, 8'hF8);
      reg_rd(`LFP_OFS_LOW, 8'hA5);
      prog_mode_in <= 1'b1;
      tick(2);
      cmd(lfp_pkg::LFP_OP_WR_HIGH, 8'hDF, 1'b0);
      tick(1);
      cmd(lfp_pkg::LFP_OP_ERASE, 8'h00, 1'b0);
      check("erase", {7'h0, eeprom_erase_out}, 8'h01);
      // every pair of lock modes, random source region and vector placement
      for (int i = 0; i < 16; i++)
      begin
         lk = i[3:0];
         vb = 1'($random(seed));
         prog_mode_in <= 1'b1;
         tick(2);
         cmd(lfp_pkg::LFP_OP_ERASE, 8'h00, 1'b0);
         cmd(lfp_pkg::LFP_OP_WR_LOCK, {2'b11, lk, 2'b11}, 1'b0);
         prog_mode_in <= 1'b0;
         reg_wr(`LFP_OFS_CTRL, {7'h0, vb});
         reg_rd(`LFP_OFS_CTRL, {7'h0, vb});
         tick(2);
         for (int k = 0; k < 4; k++)
         begin
            fb = 1'($random(seed));
            access(k[0], fb, k[1], acc_ok(lk, k[0], fb, k[1]));
         end
         for (int k = 0; k < 2; k++)
         begin
            cpu_in_boot_in <= k[0];
            tick(3);
            check("irq", {7'h0, irq_disable_out}, {7'h0, irq_exp(vb, lk, k[0])});
         end
      end
      // first memory lock freezes fuses and further programming
      prog_mode_in <= 1'b1;
      tick(2);
      cmd(lfp_pkg::LFP_OP_ERASE, 8'h00, 1'b0);
      cmd(lfp_pkg::LFP_OP_WR_LOCK, 8'hFE, 1'b0);
      tick(1);
      check("prog allow", {7'h0, mem_prog_allow_out}, 8'h00);
      cmd(lfp_pkg::LFP_OP_WR_LOW, 8'h00, 1'b0);
      check("refused", {7'h0, prog_refused_out}, 8'h01);
      cmd(lfp_pkg::LFP_OP_WR_LOCK, 8'hFF, 1'b0);
      reg_wr(`LFP_OFS_LOCK_SET, 8'hFF);
      reg_rd(`LFP_OFS_LOCK, 8'hFE);
      // software may program lock bits but never the two unused top bits
      reg_wr(`LFP_OFS_LOCK_SET, 8'h3B);
      reg_rd(`LFP_OFS_LOCK, 8'hFA);
      prog_mode_in <= 1'b0;
      tick(3);
      check("low", fuse_low_out, 8'hA5);
      // commands outside programming mode are refused
      cmd(lfp_pkg::LFP_OP_WR_LOW, 8'h11, 1'b0);
      check("refused idle", {7'h0, prog_refused_out}, 8'h01);
      reg_rd(`LFP_OFS_STATUS, 8'h03);
      report_and_stop();
   end
endmodule : testbench
